// file: hdl/host_reg_bank.sv
// Host register bank with access attributes and four host queues
// Operation
// R01: Writes to read-only registers are ignored; contents stay unchanged.
// R02: Reads of a write-only register always return zero.
// R03: Writing one clears a write-one-to-clear bit; writing zero leaves it.
// R04: Clear-on-read bits return their value, then become zero.
// R05: Latch-low and latch-high bits hold their capture until the register is read.
// R06: Self-clearing command bits drop to zero once their action is done.
// R07: Software-reset-exempt fields keep their values across a software reset.
// R08: Host writes zeros to reserved bits and ignores their read value.
// R09: Host never writes reserved addresses and treats their reads as arbitrary.
// R10: Every reset loads all configuration registers with their defaults, except exempt fields on a software reset.
// R11: Software programs operating parameters after reset.
// R12: Four host queues: receive status, receive data, transmit status, transmit data.
// R13: Host sets receive data, transmit data and receive status capacities.
// R14: Receive status pop removes the oldest entry; peek reads it without removal.
// R15: Receive data is read destructively at eight aliases from 00h to 1Ch.
// R16: Transmit data is write-only at eight aliases from 20h to 3Ch.
// R17: Transmit status pop removes the oldest entry; peek reads it without removal.
`timescale 1ns/1ps
`default_nettype none
module host_reg_bank
   import hreg_pkg::*;
#(
   parameter int QDEPTH = 16,
   parameter int QAW = 4,
   // Arbitrary identity value
   parameter logic [31:0] ID_VALUE = 32'h0A5A_0001
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Host bus
   input wire logic [ADDR_W-1:0] host_addr,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [DATA_W-1:0] host_wdata,
   output logic [DATA_W-1:0] host_rdata,
   output logic host_ack,
   // Receive side fill
   input wire logic rx_data_push,
   input wire logic [DATA_W-1:0] rx_data_in,
   output logic rx_data_room,
   input wire logic rx_stat_push,
   input wire logic [DATA_W-1:0] rx_stat_in,
   output logic rx_stat_room,
   // Transmit side
   input wire logic tx_data_pop,
   output logic [DATA_W-1:0] tx_data_out,
   output logic tx_data_valid,
   input wire logic tx_stat_push,
   input wire logic [DATA_W-1:0] tx_stat_in,
   output logic tx_stat_room,
   // Status sources
   input wire logic [EV_W-1:0] event_in,
   input wire logic link_up,
   input wire logic err_event,
   input wire logic drop_event,
   // Configuration outputs
   output logic [DATA_W-1:0] ctrl_out,
   output logic [DATA_W-1:0] wo_out,
   output logic soft_reset_active
);
   // Capacity field clamped to the queue depth
   function automatic logic [QAW:0] cap_limit(input logic [SIZE_FLD_W-1:0] fld);
      cap_limit = (32'(fld) > QDEPTH) ? (QAW+1)'(QDEPTH) : (QAW+1)'(fld);
   endfunction

   logic [EV_W-1:0] sts;
   logic [DATA_W-1:0] size_cfg;
   logic [2:0] cmd;
   logic [1:0] latch;
   logic [DATA_W-1:0] drop_cnt;

   // Decode
   wire rd_rxd = host_rd && ((host_addr & ALIAS_MASK) == RXD_BASE);
   wire wr_txd = host_wr && ((host_addr & ALIAS_MASK) == TXD_BASE);
   wire rd_rxs_pop = host_rd && (host_addr == RXS_POP_OFS);
   wire rd_txs_pop = host_rd && (host_addr == TXS_POP_OFS);
   wire wr_sts = host_wr && (host_addr == STS_OFS);
   wire wr_ctrl = host_wr && (host_addr == CTRL_OFS);
   wire wr_size = host_wr && (host_addr == SIZE_OFS);
   wire wr_cmd = host_wr && (host_addr == CMD_OFS);
   wire wr_wo = host_wr && (host_addr == WO_OFS);
   wire rd_latch = host_rd && (host_addr == LATCH_OFS);
   wire rd_drop = host_rd && (host_addr == DROP_OFS);
   wire srst = cmd[CMD_SRST_BIT];
   wire rx_flush = cmd[CMD_RXFL_BIT] || srst;
   wire tx_flush = cmd[CMD_TXFL_BIT] || srst;

   wire [DATA_W-1:0] rxd_head;
   wire [DATA_W-1:0] rxs_head;
   wire [DATA_W-1:0] txs_head;
   wire rxd_valid;
   wire rxs_valid;
   wire txs_valid;
   wire [QAW:0] rxd_lim = cap_limit(size_cfg[SIZE_RXD_LSB +: SIZE_FLD_W]); // see R13
   wire [QAW:0] txd_lim = cap_limit(size_cfg[SIZE_TXD_LSB +: SIZE_FLD_W]); // see R13
   wire [QAW:0] rxs_lim = cap_limit(size_cfg[SIZE_RXS_LSB +: SIZE_FLD_W]); // see R13

   // Four host queues
   reg_fifo #(.W(DATA_W), .DEPTH(QDEPTH), .AW(QAW)) u_rxd ( // see R12
      .clock(clock), .sys_rst(sys_rst), .flush(rx_flush),
      .push(rx_data_push), .din(rx_data_in), .room(rx_data_room),
      .pop(rd_rxd), .dout(rxd_head), .nonempty(rxd_valid), .limit(rxd_lim)); // see R15
   reg_fifo #(.W(DATA_W), .DEPTH(QDEPTH), .AW(QAW)) u_rxs (
      .clock(clock), .sys_rst(sys_rst), .flush(rx_flush),
      .push(rx_stat_push), .din(rx_stat_in), .room(rx_stat_room),
      .pop(rd_rxs_pop), .dout(rxs_head), .nonempty(rxs_valid), .limit(rxs_lim)); // see R14
   reg_fifo #(.W(DATA_W), .DEPTH(QDEPTH), .AW(QAW)) u_txd (
      .clock(clock), .sys_rst(sys_rst), .flush(tx_flush),
      .push(wr_txd), .din(host_wdata), .room(),
      .pop(tx_data_pop), .dout(tx_data_out), .nonempty(tx_data_valid), .limit(txd_lim)); // see R16
   reg_fifo #(.W(DATA_W), .DEPTH(QDEPTH), .AW(QAW)) u_txs (
      .clock(clock), .sys_rst(sys_rst), .flush(tx_flush),
      .push(tx_stat_push), .din(tx_stat_in), .room(tx_stat_room),
      .pop(rd_txs_pop), .dout(txs_head), .nonempty(txs_valid), .limit(txd_lim)); // see R17

   // Read data selection; empty queues and unmapped addresses read zero
   wire [DATA_W-1:0] rxd_word = rxd_valid ? rxd_head : ZERO_WORD;
   wire [DATA_W-1:0] rxs_word = rxs_valid ? rxs_head : ZERO_WORD;
   wire [DATA_W-1:0] txs_word = txs_valid ? txs_head : ZERO_WORD;
   logic [DATA_W-1:0] next_rdata;

   always_comb
   begin
      next_rdata = ZERO_WORD;
      if ((host_addr & ALIAS_MASK) == RXD_BASE)
      begin
         next_rdata = rxd_word; // see R15
      end
      else if ((host_addr & ALIAS_MASK) == TXD_BASE)
      begin
         next_rdata = ZERO_WORD; // see R02
      end
      else
      begin
         unique case (host_addr)
            RXS_POP_OFS, RXS_PEEK_OFS: next_rdata = rxs_word; // see R14
            TXS_POP_OFS, TXS_PEEK_OFS: next_rdata = txs_word; // see R17
            ID_OFS: next_rdata = ID_VALUE; // see R01
            STS_OFS: next_rdata = DATA_W'(sts);
            CTRL_OFS: next_rdata = ctrl_out;
            SIZE_OFS: next_rdata = size_cfg;
            CMD_OFS: next_rdata = DATA_W'(cmd);
            LATCH_OFS: next_rdata = DATA_W'(latch); // see R05
            DROP_OFS: next_rdata = drop_cnt; // see R04
            WO_OFS: next_rdata = ZERO_WORD; // see R02
            default: next_rdata = ZERO_WORD; // see R09
         endcase
      end
   end

   // Host answer one cycle after each strobe
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         host_rdata <= ZERO_WORD;
         host_ack <= 1'b0;
      end
      else
      begin
         host_rdata <= host_rd ? next_rdata : ZERO_WORD;
         host_ack <= host_rd || host_wr;
      end
   end

   // Self-clearing commands: action runs for one cycle, then the bit drops
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cmd <= 3'h0;
      end
      else
      begin
         cmd <= wr_cmd ? host_wdata[CMD_TXFL_BIT:0] : 3'h0; // see R06
      end
   end

   // Configuration registers; software reset spares the exempt field
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_out <= CTRL_RST; // see R10
         size_cfg <= SIZE_RST; // see R10
         wo_out <= ZERO_WORD; // see R10
         soft_reset_active <= 1'b0;
      end
      else if (srst)
      begin
         ctrl_out <= (ctrl_out & CTRL_EXEMPT_MASK) | (CTRL_RST & ~CTRL_EXEMPT_MASK); // see R07
         size_cfg <= SIZE_RST; // see R10
         wo_out <= ZERO_WORD;
         soft_reset_active <= 1'b1;
      end
      else
      begin
         soft_reset_active <= 1'b0;
         if (wr_ctrl)
         begin
            ctrl_out <= host_wdata;
         end
         if (wr_size)
         begin
            size_cfg <= host_wdata & SIZE_USED_MASK; // see R13
         end
         if (wr_wo)
         begin
            wo_out <= host_wdata;
         end
      end
   end

   // Status bits: sticky, write one to clear, read to clear, latching
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sts <= STS_RST;
         latch <= LATCH_RST;
         drop_cnt <= ZERO_WORD;
      end
      else if (srst)
      begin
         sts <= STS_RST;
         latch <= LATCH_RST;
         drop_cnt <= ZERO_WORD;
      end
      else
      begin
         sts <= (sts & ~(wr_sts ? host_wdata[EV_W-1:0] : STS_RST)) | event_in; // see R03
         latch[LATCH_LOW_POS] <= rd_latch ? link_up : (latch[LATCH_LOW_POS] && link_up); // see R05
         latch[LATCH_HIGH_POS] <= rd_latch ? err_event : (latch[LATCH_HIGH_POS] || err_event); // see R05
         drop_cnt <= (rd_drop ? ZERO_WORD : drop_cnt) + DATA_W'(drop_event); // see R04
      end
   end
endmodule
`default_nettype wire

// file: hdl/hreg_pkg.sv
// Constants for the host register bank: offsets, fields and reset values
package hreg_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int EV_W = 4;
   localparam int SIZE_FLD_W = 8;
   // Address decode
   localparam logic [7:0] ALIAS_MASK = 8'hE0;
   localparam logic [7:0] RXD_BASE = 8'h00;
   localparam logic [7:0] TXD_BASE = 8'h20;
   localparam logic [7:0] RXS_POP_OFS = 8'h40;
   localparam logic [7:0] RXS_PEEK_OFS = 8'h44;
   localparam logic [7:0] TXS_POP_OFS = 8'h48;
   localparam logic [7:0] TXS_PEEK_OFS = 8'h4C;
   localparam logic [7:0] ID_OFS = 8'h50;
   localparam logic [7:0] STS_OFS = 8'h58;
   localparam logic [7:0] CTRL_OFS = 8'h5C;
   localparam logic [7:0] SIZE_OFS = 8'h6C;
   localparam logic [7:0] CMD_OFS = 8'h70;
   localparam logic [7:0] LATCH_OFS = 8'h74;
   localparam logic [7:0] DROP_OFS = 8'h78;
   localparam logic [7:0] WO_OFS = 8'h7C;
   // Reset values and fields
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_EXEMPT_MASK = 32'hFFFF_0000;
   localparam logic [31:0] SIZE_RST = 32'h00FF_FFFF;
   localparam logic [31:0] SIZE_USED_MASK = 32'h00FF_FFFF;
   localparam int SIZE_RXD_LSB = 0;
   localparam int SIZE_TXD_LSB = 8;
   localparam int SIZE_RXS_LSB = 16;
   localparam int CMD_SRST_BIT = 0;
   localparam int CMD_RXFL_BIT = 1;
   localparam int CMD_TXFL_BIT = 2;
   localparam int LATCH_LOW_POS = 0;
   localparam int LATCH_HIGH_POS = 1;
   localparam logic [1:0] LATCH_RST = 2'h0;
   localparam logic [EV_W-1:0] STS_RST = 4'h0;
endpackage

// file: hdl/reg_fifo.sv
// Queue memory with registered head word and registered room and valid flags
`timescale 1ns/1ps
`default_nettype none
module reg_fifo
   import hreg_pkg::*;
#(
   parameter int W = 32,
   parameter int DEPTH = 16,
   parameter int AW = 4
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic flush,
   // Fill side
   input wire logic push,
   input wire logic [W-1:0] din,
   output logic room,
   // Drain side
   input wire logic pop,
   output logic [W-1:0] dout,
   output logic nonempty,
   // Capacity limit
   input wire logic [AW:0] limit
);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push_ok = push && room;
   wire pop_ok = pop && nonempty;
   wire [AW-1:0] next_rd_ptr = pop_ok ? AW'(rd_ptr + 1'b1) : rd_ptr;
   wire [AW:0] next_count = flush ? '0 : (AW+1)'(count + (AW+1)'(push_ok) - (AW+1)'(pop_ok));
   wire bypass = push_ok && (wr_ptr == next_rd_ptr);

   always_ff @(posedge clock)
   begin
      if (push_ok)
      begin
         mem[wr_ptr] <= din;
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         room <= 1'b0;
         nonempty <= 1'b0;
         dout <= '0;
      end
      else
      begin
         wr_ptr <= flush ? '0 : (push_ok ? AW'(wr_ptr + 1'b1) : wr_ptr);
         rd_ptr <= flush ? '0 : next_rd_ptr;
         count <= next_count;
         room <= next_count < limit;
         nonempty <= next_count != '0;
         dout <= bypass ? din : mem[next_rd_ptr];
      end
   end
endmodule
`default_nettype wire

// file: tb/host_reg_bank_properties.sv
// Port assertions for the host register bank
`timescale 1ns/1ps
`default_nettype none
module host_reg_bank_properties
   import hreg_pkg::*;
#(
   // Arbitrary identity value
   parameter logic [31:0] ID_VALUE = 32'h0A5A_0001
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Host bus
   input wire logic [ADDR_W-1:0] host_addr,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [DATA_W-1:0] host_wdata,
   input wire logic [DATA_W-1:0] host_rdata,
   input wire logic host_ack,
   // Outputs watched
   input wire logic [DATA_W-1:0] tx_data_out,
   input wire logic tx_data_valid,
   input wire logic [DATA_W-1:0] ctrl_out,
   input wire logic [DATA_W-1:0] wo_out,
   input wire logic soft_reset_active
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire logic is_txd = (host_addr & ALIAS_MASK) == TXD_BASE;
   a_ack_follows: assert property ((host_rd || host_wr) |=> host_ack)
      else $error("no ack after strobe");
   a_ack_cause: assert property (host_ack |-> $past(host_rd || host_wr))
      else $error("ack without strobe");
   a_wo_zero: assert property (host_rd && (is_txd || host_addr == WO_OFS) |=>
      host_rdata == ZERO_WORD) else $error("write-only read not zero");
   a_id_fixed: assert property (host_rd && host_addr == ID_OFS |=>
      host_rdata == ID_VALUE) else $error("read-only value changed");
   a_srst_pulse: assert property (host_wr && host_addr == CMD_OFS &&
      host_wdata[CMD_SRST_BIT] |-> ##[1:3] soft_reset_active) else $error("no soft reset");
   a_srst_defaults: assert property (soft_reset_active |->
      ctrl_out[15:0] == 16'h0000 && wo_out == ZERO_WORD) else $error("defaults not loaded");
   a_exempt_hold: assert property ($changed(ctrl_out[31:16]) |->
      $past(host_wr && host_addr == CTRL_OFS)) else $error("exempt field moved");
   a_txd_bypass: assert property (host_wr && is_txd && !tx_data_valid |=>
      tx_data_valid && tx_data_out == $past(host_wdata)) else $error("tx word lost");
endmodule
bind host_reg_bank host_reg_bank_properties #(.ID_VALUE(ID_VALUE)) props_i (.clock, .sys_rst,
   .host_addr, .host_rd, .host_wr, .host_wdata, .host_rdata, .host_ack, .tx_data_out,
   .tx_data_valid, .ctrl_out, .wo_out, .soft_reset_active);
`default_nettype wire

// file: tb/link_model.sv
// Link side model: fills the queues and drains transmit data with stalls
`timescale 1ns/1ps
`default_nettype none
module link_model
   import hreg_pkg::*;
(
   // Clock and drain enable
   input wire logic clock,
   input wire logic drain,
   // Fill ports
   output logic rx_data_push,
   output logic [DATA_W-1:0] rx_data_in,
   output logic rx_stat_push,
   output logic [DATA_W-1:0] rx_stat_in,
   output logic tx_stat_push,
   output logic [DATA_W-1:0] tx_stat_in,
   // Drain port
   output logic tx_data_pop,
   input wire logic [DATA_W-1:0] tx_data_out,
   input wire logic tx_data_valid
);
   logic [DATA_W-1:0] got[$];
   initial
   begin
      {rx_data_push, rx_stat_push, tx_stat_push, tx_data_pop} = 4'h0;
      {rx_data_in, rx_stat_in, tx_stat_in} = '0;
   end
   // Push one word into queue k, then scramble the idle data
   task automatic put(input int k, input logic [DATA_W-1:0] w);
      @(negedge clock);
      {rx_data_push, rx_stat_push, tx_stat_push} = 3'h4 >> k;
      {rx_data_in, rx_stat_in, tx_stat_in} = {3{w}};
      @(negedge clock);
      {rx_data_push, rx_stat_push, tx_stat_push} = 3'h0;
      {rx_data_in, rx_stat_in, tx_stat_in} = {3{~w}};
   endtask
   always @(negedge clock)
      tx_data_pop <= drain && 1'($urandom_range(1));
   always @(posedge clock)
      if (tx_data_pop && tx_data_valid)
         got.push_back(tx_data_out);
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the host register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import hreg_pkg::*;
   // Arbitrary identity value
   localparam logic [31:0] ID_VALUE = 32'h1234_ABCD;
   logic clock, sys_rst, host_rd, host_wr, host_ack, link_up, err_event, drop_event, drain;
   logic rx_data_push, rx_stat_push, tx_stat_push, tx_data_pop, tx_data_valid;
   logic rx_data_room, rx_stat_room, tx_stat_room, soft_reset_active;
   logic [ADDR_W-1:0] host_addr;
   logic [DATA_W-1:0] host_wdata, host_rdata, ctrl_out, wo_out, tx_data_out;
   logic [DATA_W-1:0] rx_data_in, rx_stat_in, tx_stat_in, r;
   logic [DATA_W-1:0] w[8];
   logic [EV_W-1:0] event_in;
   logic [DATA_W-1:0] exp_q[$];
   int fails, checks, cyc;
   host_reg_bank #(.ID_VALUE(ID_VALUE)) host_reg_bank_i (.clock, .sys_rst, .host_addr,
      .host_rd, .host_wr, .host_wdata, .host_rdata, .host_ack, .rx_data_push, .rx_data_in,
      .rx_data_room, .rx_stat_push, .rx_stat_in, .rx_stat_room, .tx_data_pop, .tx_data_out,
      .tx_data_valid, .tx_stat_push, .tx_stat_in, .tx_stat_room, .event_in, .link_up,
      .err_event, .drop_event, .ctrl_out, .wo_out, .soft_reset_active);
   link_model link_model_i (.clock, .drain, .rx_data_push, .rx_data_in, .rx_stat_push,
      .rx_stat_in, .tx_stat_push, .tx_stat_in, .tx_data_pop, .tx_data_out, .tx_data_valid);
   initial
   begin
      clock = 0;
      forever #10 clock = ~clock;
   end
   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
      checks++;
      if (seen !== want)
      begin
         fails++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   // One host access; a read notes d as its expected data, a write expects zero
   task automatic acc(input logic wr, input logic [7:0] a, input logic [DATA_W-1:0] d);
      @(negedge clock);
      host_rd = !wr;
      host_wr = wr;
      host_addr = a;
      host_wdata = wr ? d : ZERO_WORD;
      exp_q.push_back(wr ? ZERO_WORD : d);
      @(negedge clock);
      host_rd = 0;
      host_wr = 0;
   endtask
   task automatic print_verdict;
      chk(32'(exp_q.size()), ZERO_WORD);
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(negedge clock)
      if (host_ack === 1'b1)
         chk(host_rdata, exp_q.pop_front());
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         print_verdict;
      end
   end
   initial
   begin
      {sys_rst, link_up} = 2'h3;
      {host_rd, host_wr, err_event, drop_event, drain} = 5'h0;
      {host_addr, host_wdata, event_in} = '0;
      r = $urandom(32'h8161);
      repeat (20) @(posedge clock);
      @(negedge clock);
      sys_rst = 0;
      acc(0, CTRL_OFS, CTRL_RST);
      acc(0, LATCH_OFS, 32'(LATCH_RST));
      acc(0, LATCH_OFS, 32'h1);
      @(negedge clock);
      {link_up, err_event} = 2'h1;
      @(negedge clock);
      {link_up, err_event} = 2'h2;
      acc(0, LATCH_OFS, 32'h2);
      acc(0, LATCH_OFS, 32'h1);
      r = $urandom;
      acc(1, ID_OFS, r);
      acc(0, ID_OFS, ID_VALUE);
      acc(1, WO_OFS, r);
      chk(wo_out, r);
      acc(0, WO_OFS, ZERO_WORD);
      acc(0, 8'h24, ZERO_WORD);
      @(negedge clock);
      event_in = 4'hF;
      @(negedge clock);
      event_in = 4'h0;
      acc(0, STS_OFS, 32'hF);
      acc(1, STS_OFS, 32'h5);
      acc(0, STS_OFS, 32'hA);
      acc(1, STS_OFS, 32'h0);
      acc(0, STS_OFS, 32'hA);
      drop_event = 1;
      repeat (3) @(negedge clock);
      drop_event = 0;
      acc(0, DROP_OFS, 32'h3);
      acc(0, DROP_OFS, ZERO_WORD);
      for (int i = 0; i < 8; i++)
      begin
         w[i] = $urandom;
         link_model_i.put(0, w[i]);
      end
      for (int i = 0; i < 8; i++)
         acc(0, RXD_BASE + 8'(4 * i), w[i]);
      acc(0, 8'h1C, ZERO_WORD);
      for (int q = 0; q < 2; q++)
      begin
         link_model_i.put(q + 1, w[0]);
         link_model_i.put(q + 1, w[1]);
         acc(0, 8'(q * 8) + RXS_PEEK_OFS, w[0]);
         acc(0, 8'(q * 8) + RXS_PEEK_OFS, w[0]);
         acc(0, 8'(q * 8) + RXS_POP_OFS, w[0]);
         acc(0, 8'(q * 8) + RXS_POP_OFS, w[1]);
         acc(0, 8'(q * 8) + RXS_POP_OFS, ZERO_WORD);
      end
      for (int i = 0; i < 8; i++)
         acc(1, TXD_BASE + 8'(4 * i), w[i]);
      drain = 1;
      wait (link_model_i.got.size() == 8);
      drain = 0;
      for (int i = 0; i < 8; i++)
         chk(link_model_i.got[i], w[i]);
      acc(1, SIZE_OFS, 32'h0002_0202);
      for (int k = 0; k < 3; k++)
      begin
         link_model_i.put(k, w[2]);
         link_model_i.put(k, w[3]);
      end
      chk(32'({rx_data_room, rx_stat_room, tx_stat_room}), ZERO_WORD);
      link_model_i.put(0, w[4]);
      acc(0, RXD_BASE, w[2]);
      acc(0, RXD_BASE, w[3]);
      acc(0, RXD_BASE, ZERO_WORD);
      acc(1, CMD_OFS, 32'h2);
      acc(0, RXS_PEEK_OFS, ZERO_WORD);
      acc(0, TXS_PEEK_OFS, w[2]);
      acc(1, CMD_OFS, 32'h4);
      acc(0, TXS_PEEK_OFS, ZERO_WORD);
      acc(1, CTRL_OFS, r);
      acc(1, WO_OFS, r);
      acc(1, CMD_OFS, 32'h1);
      acc(0, CMD_OFS, ZERO_WORD);
      chk(ctrl_out, r & CTRL_EXEMPT_MASK);
      chk(wo_out, ZERO_WORD);
      acc(0, SIZE_OFS, SIZE_RST);
      chk(32'({rx_data_room, rx_stat_room, tx_stat_room}), 32'h7);
      repeat (2) @(negedge clock);
      print_verdict;
   end
endmodule
`default_nettype wire
